// ### hw/pwr_button_ctrl.sv
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
// Function
// - Supply request on powers all rails
// - Off: press edge turns supply on
// - On, no ACPI: press turns supply off
// - On, ACPI: press raises SMI, status, timer
// - Guard expiry with status set powers off
// - Hold four seconds then release powers off
// - Green steady on, 0.5 Hz in sleep, dark while a blink code shows
// - Red blinks fault count at 1 Hz
// - Beeps match blinks, 2 s pause, 5 rounds
// - Each wake source individually enabled
// - Serial ring wakes when enabled
// - PCI PME wakes when enabled
module pwr_button_ctrl #(
  parameter int unsigned FOUR_SEC = pwr_ctrl_pkg::FOUR_SEC_CYCLES,
  parameter int unsigned HALF_SEC = pwr_ctrl_pkg::HALF_SEC_CYCLES,
  parameter int unsigned DEBOUNCE = pwr_ctrl_pkg::DEBOUNCE_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus, write side
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [7:0] awaddr_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // Register bus, read side
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [7:0] araddr_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  // Front panel and wake pins, active low
  input wire logic button_n_i,
  input wire logic ring_n_i,
  input wire logic pci_pme_n_i,
  input wire logic nic_pme_n_i,
  // Supply, interrupt and indicators
  output logic supply_on_request_o,
  output logic sys_mgmt_irq_n_o,
  output logic led_green_o,
  output logic led_red_o,
  output logic beep_o
);
  import pwr_ctrl_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // Input filtering
  // Filtered levels and edges
  logic btn_level, btn_fall, btn_rise;
  logic ring_fall, pme_fall, magic_fall;

  // Button gets a full debounce
  pin_filter #(.SETTLE_CYCLES(DEBOUNCE)) u_btn (.clk_i(clk_i), .rst_i(rst_i), .pin_n_i(button_n_i),
    .level_o(btn_level), .fall_o(btn_fall), .rise_o(btn_rise));

  // Serial ring indicator
  pin_filter #(.SETTLE_CYCLES(1)) u_ring (.clk_i(clk_i), .rst_i(rst_i), .pin_n_i(ring_n_i),
    .level_o(), .fall_o(ring_fall), .rise_o());

  // PCI power management event
  pin_filter #(.SETTLE_CYCLES(1)) u_pme (.clk_i(clk_i), .rst_i(rst_i), .pin_n_i(pci_pme_n_i),
    .level_o(), .fall_o(pme_fall), .rise_o());

  // Network controller wake line
  pin_filter #(.SETTLE_CYCLES(1)) u_magic (.clk_i(clk_i), .rst_i(rst_i), .pin_n_i(nic_pme_n_i),
    .level_o(), .fall_o(magic_fall), .rise_o());

  ////////////////////////////////////////////////////////////////////////////////
  // State declarations
  pwr_state_t pwr_state; // Current power state
  pwr_state_t next_state; // Next power state
  logic acpi_en; // ACPI mode
  logic wake_magic_en, wake_ring_en, wake_pme_en; // Wake enables
  logic btn_status; // Button status, write one to clear
  logic smi_src; // Interrupt source, write one to clear
  logic four_run; // Four-second counter active
  logic [31:0] four_cnt; // Four-second counter
  logic [3:0] fault_code; // Blink code shown, zero for none
  logic [31:0] half_cnt; // Half-second divider
  logic half_tick; // One pulse per half second
  logic [4:0] red_seq; // Position inside a red round
  logic [2:0] red_rounds; // Completed red rounds
  logic [1:0] green_ph; // Sleep blink phase

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode
  // Write accepted when both channels are offered and no answer pends
  wire logic wr_go = awvalid_i && wvalid_i && !awready_o && !bvalid_o;
  wire logic wr_fire = awready_o && awvalid_i && wvalid_i;
  wire logic rd_go = arvalid_i && !arready_o && !rvalid_o;
  wire logic rd_fire = arready_o && arvalid_i;

  // Write address match
  wire logic wsel_ctrl = (awaddr_i == ADDR_CTRL);
  wire logic wsel_stat = (awaddr_i == ADDR_STATUS);
  wire logic wsel_fault = (awaddr_i == ADDR_FAULT);
  wire logic wr_hit = wsel_ctrl || wsel_stat || wsel_fault;
  wire logic wr_lane = wr_fire && wstrb_i[0];

  // Register write strobes
  wire logic ctrl_wr = wr_lane && wsel_ctrl;
  wire logic fault_wr = wr_lane && wsel_fault;
  wire logic sleep_req = ctrl_wr && wdata_i[CTRL_SLEEP_BIT];
  wire logic clr_btn = wr_lane && wsel_stat && wdata_i[STAT_BTN_BIT];
  wire logic clr_smi = wr_lane && wsel_stat && wdata_i[STAT_SMI_BIT];

  // Only documented blink codes are stored
  wire logic fault_ok = (wdata_i[3:0] >= FAULT_MIN) && (wdata_i[3:0] <= FAULT_MAX);
  wire logic [3:0] fault_in = fault_ok ? wdata_i[3:0] : FAULT_NONE;

  // Read address match and data
  wire logic rsel_ctrl = (araddr_i == ADDR_CTRL);
  wire logic rsel_stat = (araddr_i == ADDR_STATUS);
  wire logic rsel_fault = (araddr_i == ADDR_FAULT);
  wire logic rd_hit = rsel_ctrl || rsel_stat || rsel_fault;
  wire logic [31:0] ctrl_word = {28'h0, wake_pme_en, wake_ring_en, wake_magic_en, acpi_en};
  wire logic [31:0] stat_word = {25'h0, pwr_state, four_run, supply_on_request_o, smi_src, btn_status};
  wire logic [31:0] rd_word = rsel_ctrl ? ctrl_word :
                              rsel_stat ? stat_word :
                              rsel_fault ? {28'h0, fault_code} : 32'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake
  // Ready pulses and write answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      awready_o <= 1'b0;
      wready_o <= 1'b0;
      bvalid_o <= 1'b0;
      bresp_o <= RESP_OKAY;
    end else begin
      awready_o <= wr_go;
      wready_o <= wr_go;
      if (wr_fire) begin
        bvalid_o <= 1'b1;
        bresp_o <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready_i) begin
        bvalid_o <= 1'b0;
      end
    end
  end

  // Read answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arready_o <= 1'b0;
      rvalid_o <= 1'b0;
      rdata_o <= 32'h0;
      rresp_o <= RESP_OKAY;
    end else begin
      arready_o <= rd_go;
      if (rd_fire) begin
        rvalid_o <= 1'b1;
        rdata_o <= rd_word;
        rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready_i) begin
        rvalid_o <= 1'b0;
      end
    end
  end

  // Control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {wake_pme_en, wake_ring_en, wake_magic_en, acpi_en} <= CTRL_RESET;
    end else if (ctrl_wr) begin
      acpi_en <= wdata_i[CTRL_ACPI_BIT];
      wake_magic_en <= wdata_i[CTRL_MAGIC_BIT];
      wake_ring_en <= wdata_i[CTRL_RING_BIT];
      wake_pme_en <= wdata_i[CTRL_PME_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power sequencing
  // Only enabled sources count as wake
  wire logic wake_hit = (magic_fall && wake_magic_en)
                     || (ring_fall && wake_ring_en)
                     || (pme_fall && wake_pme_en);
  wire logic is_on = (pwr_state == PWR_ON);
  wire logic acpi_press = is_on && acpi_en && btn_fall;
  wire logic four_done = (four_cnt >= FOUR_SEC - 1);
  wire logic guard_trip = four_run && four_done && btn_status;
  wire logic hold_trip = four_run && four_done && btn_rise;
  wire logic leave_on = is_on && (next_state != PWR_ON);

  // Sticky bits: a new press wins over a clear in the same cycle
  wire logic next_btn_status = acpi_press || (btn_status && !clr_btn && !leave_on);
  wire logic next_smi_src = acpi_press || (smi_src && !clr_smi && !leave_on);
  wire logic next_four_run = acpi_press || (four_run && !leave_on && (next_btn_status || !btn_level));

  // Next power state
  always_comb begin
    next_state = pwr_state;
    case (pwr_state)
      PWR_OFF: begin
        if (btn_fall || wake_hit) begin
          next_state = PWR_ON;
        end
      end
      PWR_SLEEP: begin
        if (btn_fall || wake_hit) begin
          next_state = PWR_ON;
        end
      end
      PWR_ON: begin
        if (btn_fall && !acpi_en) begin
          next_state = PWR_OFF;
        end else if (guard_trip || hold_trip) begin
          next_state = PWR_OFF;
        end else if (sleep_req && !acpi_press) begin
          next_state = PWR_SLEEP;
        end
      end
      default: begin
        next_state = PWR_OFF;
      end
    endcase
  end

  // State, supply request and interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_state <= PWR_OFF;
      supply_on_request_o <= 1'b0;
      btn_status <= 1'b0;
      smi_src <= 1'b0;
      sys_mgmt_irq_n_o <= 1'b1;
      four_run <= 1'b0;
    end else begin
      pwr_state <= next_state;
      supply_on_request_o <= (next_state == PWR_ON);
      btn_status <= next_btn_status;
      smi_src <= next_smi_src;
      sys_mgmt_irq_n_o <= !next_smi_src;
      four_run <= next_four_run;
    end
  end

  // Four-second counter, saturating; a new press restarts it, leaving ON idles it at once
  always_ff @(posedge clk_i) begin
    if (rst_i || !four_run || acpi_press || leave_on) begin
      four_cnt <= 32'h0;
    end else if (!four_done) begin
      four_cnt <= four_cnt + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Indicator timing
  // Half-second tick, restarted by a new blink code
  always_ff @(posedge clk_i) begin
    if (rst_i || fault_wr || half_cnt >= HALF_SEC - 1) begin
      half_cnt <= 32'h0;
    end else begin
      half_cnt <= half_cnt + 32'h1;
    end
  end

  // Tick pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      half_tick <= 1'b0;
    end else begin
      half_tick <= !fault_wr && (half_cnt >= HALF_SEC - 1);
    end
  end

  // Red round length: two ticks per blink plus the pause
  wire logic [4:0] blink_ticks = {fault_code, 1'b0};
  wire logic [4:0] red_period = blink_ticks + PAUSE_TICKS;
  wire logic red_phase = (fault_code != FAULT_NONE) && (red_seq < blink_ticks) && !red_seq[0];
  wire logic beep_phase = red_phase && (red_rounds < BEEP_ROUNDS);

  // Blink code register and round sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_code <= FAULT_NONE;
      red_seq <= 5'h0;
      red_rounds <= 3'h0;
    end else if (fault_wr) begin
      fault_code <= fault_in;
      red_seq <= 5'h0;
      red_rounds <= 3'h0;
    end else if (half_tick) begin
      if (red_seq >= red_period - 5'h1) begin
        red_seq <= 5'h0;
        if (red_rounds < BEEP_ROUNDS) begin
          red_rounds <= red_rounds + 3'h1;
        end
      end else begin
        red_seq <= red_seq + 5'h1;
      end
    end
  end

  // Green sleep phase: two ticks lit, two dark
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      green_ph <= 2'h0;
    end else if (half_tick) begin
      green_ph <= green_ph + 2'h1;
    end
  end

  // LED and beeper drive, red code has priority
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      led_green_o <= 1'b0;
      led_red_o <= 1'b0;
      beep_o <= 1'b0;
    end else begin
      led_green_o <= (fault_code == FAULT_NONE) && (is_on || (pwr_state == PWR_SLEEP && !green_ph[1]));
      led_red_o <= red_phase;
      beep_o <= beep_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_supply_state: assert property (@(posedge clk_i) disable iff (rst_i)
    supply_on_request_o == is_on) else $error("supply request disagrees with state");
  a_off_press: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwr_state == PWR_OFF && btn_fall) |=> supply_on_request_o && !four_run)
    else $error("press while off did not turn supply on");
  a_plain_press: assert property (@(posedge clk_i) disable iff (rst_i)
    (is_on && !acpi_en && btn_fall) |=> !supply_on_request_o && four_cnt == 32'h0)
    else $error("press without ACPI did not turn supply off");
  a_acpi_press: assert property (@(posedge clk_i) disable iff (rst_i)
    acpi_press |=> btn_status && smi_src && !sys_mgmt_irq_n_o && four_run ##1 four_cnt == 32'h1)
    else $error("ACPI press did not raise interrupt and start counter");
  a_guard_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (is_on && four_run && four_done && btn_status) |=> !supply_on_request_o && !btn_status)
    else $error("guard expiry did not turn supply off");
  a_hold_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (is_on && hold_trip) |=> pwr_state == PWR_OFF)
    else $error("long press release did not turn supply off");
  a_green_state: assert property (@(posedge clk_i) disable iff (rst_i)
    (fault_code == FAULT_NONE && pwr_state == PWR_OFF) |=> !led_green_o)
    else $error("green lit while off");
  a_red_none: assert property (@(posedge clk_i) disable iff (rst_i)
    (fault_code == FAULT_NONE) |=> !led_red_o) else $error("red lit with no fault");
  a_beep_red: assert property (@(posedge clk_i) disable iff (rst_i)
    beep_o |-> led_red_o && $past(red_rounds) < BEEP_ROUNDS) else $error("beep without red blink");
  a_wake_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (!is_on && !btn_fall && !wake_hit) |=> !supply_on_request_o) else $error("supply came on without an enabled wake");
  a_ring_wake: assert property (@(posedge clk_i) disable iff (rst_i)
    (!is_on && ring_fall && wake_ring_en) |=> supply_on_request_o) else $error("ring did not wake");
  a_pme_wake: assert property (@(posedge clk_i) disable iff (rst_i)
    (!is_on && pme_fall && wake_pme_en) |=> supply_on_request_o) else $error("PME did not wake");
  c_power_up: cover property (@(posedge clk_i) disable iff (rst_i) pwr_state == PWR_OFF ##1 is_on);
  c_acpi_press: cover property (@(posedge clk_i) disable iff (rst_i) acpi_press);
  c_sleep_wake: cover property (@(posedge clk_i) disable iff (rst_i) pwr_state == PWR_SLEEP && wake_hit);
  c_beep: cover property (@(posedge clk_i) disable iff (rst_i) $rose(beep_o));
endmodule

// ### hw/pwr_ctrl_pkg.sv
package pwr_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and time figures
  localparam int unsigned CLK_KHZ = 40000; // 40 MHz core clock
  localparam int unsigned FOUR_SEC_MS = 4000; // Guard and long-press time
  localparam int unsigned HALF_SEC_MS = 500; // Blink time base
  localparam int unsigned DEBOUNCE_MS = 10; // Button settle time
  localparam int unsigned FOUR_SEC_CYCLES = FOUR_SEC_MS * CLK_KHZ;
  localparam int unsigned HALF_SEC_CYCLES = HALF_SEC_MS * CLK_KHZ;
  localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_KHZ;

  ////////////////////////////////////////////////////////////////////////////////
  // Blink and beep sequencing, counted in half-second ticks
  localparam logic [4:0] PAUSE_TICKS = 5'h04; // 2 s pause between rounds
  localparam logic [2:0] BEEP_ROUNDS = 3'h5; // Beeps stop after 5 rounds
  localparam logic [3:0] FAULT_MIN = 4'h2; // Lowest blink code
  localparam logic [3:0] FAULT_MAX = 4'ha; // Highest blink code
  localparam logic [3:0] FAULT_NONE = 4'h0; // No fault shown

  ////////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FAULT = 8'h08;

  // Control fields
  localparam int unsigned CTRL_ACPI_BIT = 0;
  localparam int unsigned CTRL_MAGIC_BIT = 1;
  localparam int unsigned CTRL_RING_BIT = 2;
  localparam int unsigned CTRL_PME_BIT = 3;
  localparam int unsigned CTRL_SLEEP_BIT = 4;

  // Status fields
  localparam int unsigned STAT_BTN_BIT = 0;
  localparam int unsigned STAT_SMI_BIT = 1;

  // Reset values
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Power states, one-hot
  typedef enum logic [2:0] {
    PWR_OFF = 3'h1,
    PWR_ON = 3'h2,
    PWR_SLEEP = 3'h4
  } pwr_state_t;

endpackage

// ### hw/pin_filter.sv
`timescale 1ns/100ps
module pin_filter #(
  parameter int unsigned SETTLE_CYCLES = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw pin, idle high
  input wire logic pin_n_i,
  // Filtered level and edges
  output logic level_o,
  output logic fall_o,
  output logic rise_o
);

  // Three-stage synchroniser
  logic s1;
  logic s2;
  logic s3;
  // Settle counter
  logic [31:0] cnt;

  // Change is seen only once stages two and three agree
  wire logic differs = (s2 == s3) && (s3 != level_o);
  wire logic settled = (cnt >= SETTLE_CYCLES - 1);

  // Synchroniser chain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end else begin
      s1 <= pin_n_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Level accepted after a quiet settle time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 32'h0;
      level_o <= 1'b1;
      fall_o <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      fall_o <= differs && settled && !s3;
      rise_o <= differs && settled && s3;
      if (!differs) begin
        cnt <= 32'h0;
      end else if (settled) begin
        cnt <= 32'h0;
        level_o <= s3;
      end else begin
        cnt <= cnt + 32'h1;
      end
    end
  end

  // One edge pulse per accepted change
  a_single_edge: assert property (@(posedge clk_i) disable iff (rst_i) fall_o |=> !fall_o)
    else $error("falling edge pulse longer than one cycle");

endmodule

// ### sim/pwr_panel_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Front-panel button and network controller stand-in
module pwr_panel_model (
  // Bench requests
  input wire logic press_i,
  input wire logic magic_i,
  // Pins towards the block
  output logic button_n_o,
  output logic nic_pme_n_o
);
  // Button grounds the line while held, pull-up otherwise
  assign button_n_o = ~press_i;
  // Magic packet seen: controller pulls its wake line low
  assign nic_pme_n_o = ~magic_i;
endmodule

// ### sim/pwr_button_ctrl_tb_top.sv
`timescale 1ns/100ps
module pwr_button_ctrl_tb_top;
  import pwr_ctrl_pkg::*;
  localparam int FS = 40; // Shortened guard time
  localparam int HS = 8; // Shortened half second
  ////////////////////////////////////////////////////////////////////////////////
  // Bench signals
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic ring_n = 1'h1, pci_n = 1'h1, press = 1'h0, magic = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, supply, irq_n, green, red, beep, button_n, nic_n;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int fail_count = 0;
  int num_checks = 0;
  // Free-running clock
  always #12.5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  // Block and far side
  pwr_button_ctrl #(.FOUR_SEC(FS), .HALF_SEC(HS), .DEBOUNCE(4)) i_pwr_button_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .awvalid_i(awvalid), .awready_o(awready), .awaddr_i(awaddr),
    .wvalid_i(wvalid), .wready_o(wready), .wdata_i(wdata), .wstrb_i(wstrb), .bvalid_o(bvalid),
    .bready_i(bready), .bresp_o(bresp), .arvalid_i(arvalid), .arready_o(arready), .araddr_i(araddr),
    .rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata), .rresp_o(rresp), .button_n_i(button_n),
    .ring_n_i(ring_n), .pci_pme_n_i(pci_n), .nic_pme_n_i(nic_n), .supply_on_request_o(supply),
    .sys_mgmt_irq_n_o(irq_n), .led_green_o(green), .led_red_o(red), .beep_o(beep));
  pwr_panel_model i_pwr_panel_model (.press_i(press), .magic_i(magic), .button_n_o(button_n),
    .nic_pme_n_o(nic_n));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare, bus and pin tasks
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s exp %h got %h", $time, what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_word(what, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic tap(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Expected status word: one-hot state above four flag bits
  function automatic logic [31:0] stat_exp(input pwr_state_t st, input logic [3:0] flags);
    stat_exp = {25'h0, st, flags};
  endfunction
  // Cycles in one red round: two ticks per blink plus the pause
  function automatic int round_cyc(input int code);
    round_cyc = (2 * code + int'(PAUSE_TICKS)) * HS;
  endfunction
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_i);
      if (!aw_ok && awready === 1'h1) begin
        aw_ok = 1'h1;
        awvalid <= 1'h0;
      end
      if (!w_ok && wready === 1'h1) begin
        w_ok = 1'h1;
        wvalid <= 1'h0;
      end
    end
    bready <= 1'h1;
    do @(posedge clk_i); while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge clk_i); while (arready !== 1'h1);
    arvalid <= 1'h0;
    rready <= 1'h1;
    do @(posedge clk_i); while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, 4'hf, r);
    chk_word("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask
  // Masked register read against expectation
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk_word("rdata", e, d & m);
    chk_word("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask
  // Contact bounce shorter than the settle time, then press held, released and settled
  task automatic push(input int hold);
    press <= 1'h1;
    tap(1 + $urandom_range(0, 1));
    press <= 1'h0;
    tap(2);
    press <= 1'h1;
    tap(hold);
    press <= 1'h0;
    tap(12);
  endtask
  // Wake pulse on source 1 magic, 2 ring, 3 PME
  task automatic wake(input int src);
    magic <= (src == 1);
    ring_n <= (src != 2);
    pci_n <= (src != 3);
    tap(6);
    magic <= 1'h0;
    ring_n <= 1'h1;
    pci_n <= 1'h1;
    tap(8);
  endtask
  // Green high cycles, red rises, beep high cycles, beep versus red mismatches
  task automatic samp(input int cyc, output int g, output int rise, output int bp, output int mis);
    logic prev;
    prev = 1'h0;
    g = 0;
    rise = 0;
    bp = 0;
    mis = 0;
    repeat (cyc) begin
      @(posedge clk_i);
      g += int'(green === 1'h1);
      rise += int'(red === 1'h1 && !prev);
      bp += int'(beep === 1'h1);
      mis += int'(beep !== red);
      prev = red;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    tap(40000);
    fail_count++;
    end_of_test();
  end
  // Main sequence
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    int n, rnd, g, ri, bp, mis;
    void'($urandom(82040));
    tap(8);
    rst_i <= 1'h0;
    tap(1);
    rdc(ADDR_CTRL, 32'hff, 32'h0);
    rdc(ADDR_STATUS, 32'h7f, stat_exp(PWR_OFF, 4'h0));
    rd(8'h0c, d, r);
    chk_word("rd unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(8'h0c, 32'h1, 4'hf, r);
    chk_word("wr unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(ADDR_CTRL, 32'h1, 4'h0, r);
    chk_word("wr no lane", {30'h0, RESP_OKAY}, {30'h0, r});
    rdc(ADDR_CTRL, 32'hff, 32'h0);
    $display("reset test done");
    push(8);
    chk_bit("on", 1'h1, supply);
    rdc(ADDR_STATUS, 32'h7f, stat_exp(PWR_ON, 4'h4));
    push(8);
    chk_bit("off", 1'h0, supply);
    rdc(ADDR_STATUS, 32'h7f, stat_exp(PWR_OFF, 4'h0));
    $display("plain button test done");
    push(8);
    wrc(ADDR_CTRL, 32'h1);
    push(8);
    chk_bit("smi", 1'h0, irq_n);
    rdc(ADDR_STATUS, 32'h7f, stat_exp(PWR_ON, 4'hf));
    wrc(ADDR_STATUS, 32'h3);
    tap(FS + 10);
    chk_bit("smi clr", 1'h1, irq_n);
    chk_bit("kept on", 1'h1, supply);
    push(8);
    tap(FS + 5);
    chk_bit("guard off", 1'h0, supply);
    push(8);
    press <= 1'h1;
    tap(12);
    wrc(ADDR_STATUS, 32'h3);
    tap(FS + $urandom_range(0, 20));
    chk_bit("held on", 1'h1, supply);
    press <= 1'h0;
    tap(12);
    chk_bit("long off", 1'h0, supply);
    wrc(ADDR_CTRL, 32'h0);
    $display("acpi test done");
    push(8);
    samp(8 * HS, g, ri, bp, mis);
    chk_word("green on", 8 * HS, g);
    wrc(ADDR_CTRL, 32'h10);
    tap(2);
    samp(8 * HS, g, ri, bp, mis);
    chk_word("green sleep", 4 * HS, g);
    push(8);
    for (int c = 2; c <= 10; c++) begin
      wrc(ADDR_FAULT, c);
      samp(round_cyc(c) - 4, g, ri, bp, mis);
      chk_word("blinks", c, ri);
    end
    n = $urandom_range(2, 10);
    rnd = round_cyc(n);
    wrc(ADDR_FAULT, n);
    samp(rnd - 4, g, ri, bp, mis);
    chk_word("beeps", 32'h0, mis);
    tap(4 + 4 * rnd);
    samp(rnd - 4, g, ri, bp, mis);
    chk_word("red on", n, ri);
    chk_word("beep stop", 32'h0, bp);
    wrc(ADDR_FAULT, 32'hb);
    rdc(ADDR_FAULT, 32'hf, 32'h0);
    $display("led test done");
    push(8);
    for (int s = 1; s <= 3; s++) begin
      wrc(ADDR_CTRL, ~(32'h1 << s) & 32'he);
      wake(s);
      chk_bit("wake off", 1'h0, supply);
      wrc(ADDR_CTRL, 32'h1 << s);
      wake(s);
      chk_bit("wake on", 1'h1, supply);
      push(8);
    end
    $display("wake test done");
    end_of_test();
  end
endmodule
